// file: bench/scfg_board_model.sv
`timescale 1ns/100ps
// Board wiring on the shared address/indicator pins
module scfg_board_model (
    input  wire logic [4:0] i_strap_addr, // Strap level wired on the board
    input  wire logic [4:0] i_oe,         // Device drive enables
    input  wire logic [4:0] i_ind,        // Device drive levels
    output logic      [4:0] o_pins        // Resolved pin levels
);
    // Strap shows while released, device level once driven
    assign o_pins = (i_oe & i_ind) | (~i_oe & i_strap_addr);
endmodule : scfg_board_model

// file: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic speed, dpx, an, mii, lmod, col; logic [4:0] addr;
        logic link, l100, fdx; logic [1:0] exp_if; logic [4:0] exp_ind;
    } scfg_row_t;
    scfg_row_t r; // Row under test
    logic clk = 0, arst_n = 0, iso = 0, rpt = 0, psave = 0, speed, dpx, an, mii, lmod, col;
    logic link = 0, l100 = 0, fdx = 0, act = 0, colln = 0, o_iso, o_rpt, o_psave;
    logic o_speed, o_dpx, o_an, mode2, s0, s1, t0, t1;
    logic [4:0] addr, pins, ind, oe, sta;
    scfg_pkg::scfg_if_t mif;
    int err_total = 0, comparisons = 0, cyc = 0;
    scfg_row_t rows [4] = '{ // Strap sets and status, with expected interface code and pins
        '{1'h1,1'h1,1'h1,1'h1,1'h0,1'h0,5'h00,1'h1,1'h1,1'h1,2'h1,5'h0B},
        '{1'h0,1'h0,1'h0,1'h0,1'h1,1'h0,5'h1F,1'h1,1'h0,1'h0,2'h0,5'h1A},
        '{1'h1,1'h0,1'h1,1'h0,1'h0,1'h1,5'h15,1'h1,1'h0,1'h1,2'h2,5'h12},
        '{1'h0,1'h1,1'h0,1'h1,1'h1,1'h1,5'h0A,1'h0,1'h1,1'h1,2'h2,5'h08}};
    scfg_strap_led #(.BLINK_CYC(4)) scfg_strap_led_i (
        .i_clk(clk), .i_arst_n(arst_n), .i_isolate_strap(iso), .i_repeater_strap(rpt),
        .i_power_save_strap(psave), .i_speed_strap(speed), .i_duplex_strap(dpx),
        .i_autoneg_strap(an), .i_mac_if_select_strap(mii), .i_indicator_mode_strap(lmod),
        .i_col_strap(col), .i_station_addr_pins(pins), .i_link_up(link),
        .i_link_100m(l100), .i_full_duplex(fdx), .i_activity(act), .i_collision(colln),
        .o_station_addr_ind(ind), .o_station_addr_oe(oe), .o_station_addr(sta),
        .o_isolate(o_iso), .o_repeater_mode(o_rpt), .o_power_save(o_psave),
        .o_speed_100(o_speed), .o_full_duplex_cfg(o_dpx), .o_autoneg_en(o_an),
        .o_mac_if(mif), .o_indicator_mode2(mode2));
    scfg_board_model scfg_board_model_i (
        .i_strap_addr(addr), .i_oe(oe), .i_ind(ind), .o_pins(pins));
    // Clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        {speed, dpx, an, mii, lmod, col, addr} = {6'h3B, 5'h00};
        // Defaults held while reset is low
        step(20);
        chk("reset cfg", 16'h0074, {o_speed, o_dpx, o_an, mif, mode2, o_iso});
        chk("reset oe", 16'h0000, oe);
        $display("test reset done");
        foreach (rows[k]) begin
            r = rows[k];
            arst_n = 0;
            {speed, dpx, an, mii} = {r.speed, r.dpx, r.an, r.mii};
            {lmod, col, addr} = {r.lmod, r.col, r.addr};
            {link, l100, fdx} = {r.link, r.l100, r.fdx};
            step(2);
            arst_n = 1;
            step(5);
            chk("latched", {r.speed, r.dpx, r.an}, {o_speed, o_dpx, o_an});
            chk("mode", r.lmod, mode2);
            chk("mac_if", r.exp_if, mif);
            chk("addr", r.addr, sta);
            chk("oe", 16'h001F, oe);
            chk("ind", r.exp_ind, ind);
            $display("test row %0d done", k);
        end
        // Pin changes after capture leave the latched set alone
        {speed, dpx, an, mii, lmod, col, addr} = {6'h24, 5'h15};
        step(4);
        chk("held", 16'h00AA, {o_speed, o_dpx, o_an, mode2, sta});
        chk("held if", 16'h0002, mif);
        $display("test hold done");
        // Live straps follow after two cycles
        for (int v = 1; v >= 0; v--) begin
            {iso, rpt, psave} = {3{v[0]}};
            step(2);
            chk("live", {3{v[0]}}, {o_iso, o_rpt, o_psave});
        end
        $display("test live done");
        // Mode two blinking on traffic and collision
        {link, act, colln, fdx} = 4'hE;
        {s0, s1, t0, t1} = 4'h0;
        repeat (24) begin
            step(1);
            if (ind[0]) s1 = 1; else s0 = 1;
            if (ind[1]) t1 = 1; else t0 = 1;
        end
        chk("link blink", 8'h03, {s0, s1});
        chk("dpx blink", 8'h03, {t0, t1});
        {act, colln, fdx} = 3'h1;
        step(3);
        chk("steady", 16'h0001, ind);
        $display("test blink done");
        // Mid-run reset: defaults at once, then a fresh capture on edge three
        arst_n = 0;
        #1;
        chk("rst cfg", 16'h0074, {o_speed, o_dpx, o_an, mif, mode2, o_iso});
        chk("rst pins", 16'h0000, {oe, ind, sta});
        step(2);
        arst_n = 1;
        step(2);
        chk("oe edge2", 16'h0000, oe);
        step(1);
        chk("oe edge3", 16'h001F, oe);
        chk("recapture", 16'h0115, {o_speed, o_dpx, o_an, mode2, sta});
        chk("recap if", 16'h0001, mif);
        step(1);
        chk("mode1 ind", 16'h001E, ind);
        $display("test rerun done");
        // Mode one: 100M pin blinks on traffic, collision pin lit
        {act, colln} = 2'h3;
        {s0, s1} = 2'h0;
        repeat (12) begin
            step(1);
            if (ind[3]) s1 = 1; else s0 = 1;
        end
        chk("100m blink", 16'h0003, {s0, s1});
        chk("mode1 col", 16'h0000, ind[4]);
        $display("test mode1 done");
        final_report();
    end
endmodule : tb_top

// file: rtl/scfg_pkg.sv
package scfg_pkg;
    // Strap defaults through the internal pulls
    localparam logic SCFG_REPEATER_DEF = 1'h0;
    localparam logic SCFG_SPEED_DEF    = 1'h1;
    localparam logic SCFG_DUPLEX_DEF   = 1'h1;
    localparam logic SCFG_ANEG_DEF  = 1'b1;
    localparam logic SCFG_PSAVE_DEF    = 1'h1;
    localparam logic SCFG_MIIS_DEF  = 1'b1;
    localparam logic SCFG_LMOD_DEF  = 1'b0;
    localparam logic SCFG_COL_DEF   = 1'b0;
    localparam logic [4:0] SCFG_ADDR_DEF = 5'h00;
    // Indicator positions
    localparam int SCFG_IND_LINK = 0;
    localparam int SCFG_IND_FDX  = 1;
    localparam int SCFG_IND_10M  = 2;
    localparam int SCFG_IND_100M = 3;
    localparam int SCFG_IND_COL  = 4;
    localparam int SCFG_IND_NUM  = 5;
    // Bit positions in the synchronised pin word
    localparam int SCFG_SYNC_W      = 14;
    localparam int SCFG_POS_ISO     = 13;
    localparam int SCFG_POS_REP     = 12;
    localparam int SCFG_POS_PSAVE   = 11;
    localparam int SCFG_POS_SPEED   = 10;
    localparam int SCFG_POS_DUPLEX  = 9;
    localparam int SCFG_POS_ANEG    = 8;
    localparam int SCFG_POS_MIF     = 7;
    localparam int SCFG_POS_LMOD    = 6;
    localparam int SCFG_POS_COL     = 5;
    localparam int SCFG_POS_ADDR_HI = 4;
    // Synchroniser fill count before the straps are taken
    localparam logic [1:0] SCFG_FILL_CYC = 2'h2;
    // Blink half period in ms and derived cycles at 250 MHz
    localparam int SCFG_CLK_KHZ        = 250000;
    localparam int SCFG_BLINK_HALF_MS  = 50;
    localparam int SCFG_BLINK_CYC      = SCFG_CLK_KHZ * SCFG_BLINK_HALF_MS;
    // Interface selection codes
    typedef enum logic [1:0] {SCFG_IF_SNI, SCFG_IF_MII, SCFG_IF_RMII} scfg_if_t;
endpackage : scfg_pkg

// file: rtl/scfg_strap_led.sv
`timescale 1ns/100ps
module scfg_strap_led #(
    parameter int BLINK_CYC = scfg_pkg::SCFG_BLINK_CYC   // Blink half period in cycles
) (
    input  wire logic       i_clk,              // Core clock
    input  wire logic       i_arst_n,           // Chip reset, active low
    input  wire logic       i_isolate_strap,    // Isolate pin
    input  wire logic       i_repeater_strap,   // Repeater pin
    input  wire logic       i_power_save_strap, // Power save pin
    input  wire logic       i_speed_strap,      // Speed strap pin
    input  wire logic       i_duplex_strap,     // Duplex strap pin
    input  wire logic       i_autoneg_strap,    // Autoneg strap pin
    input  wire logic       i_mac_if_select_strap, // Interface select pin
    input  wire logic       i_indicator_mode_strap, // Carrier sense pin level
    input  wire logic       i_col_strap,        // Collision pin level
    input  wire logic [4:0] i_station_addr_pins, // Shared address/indicator pins in
    input  wire logic       i_link_up,          // Link status from core logic
    input  wire logic       i_link_100m,        // Link speed is 100M
    input  wire logic       i_full_duplex,      // Duplex status
    input  wire logic       i_activity,         // Transmit or receive activity
    input  wire logic       i_collision,        // Collision detected
    output logic [4:0]      o_station_addr_ind, // Indicator drive levels
    output logic [4:0]      o_station_addr_oe,  // Indicator output enables
    output logic [4:0]      o_station_addr,     // Latched station address
    output logic            o_isolate,          // Detach MAC and management
    output logic            o_repeater_mode,    // Repeater mode active
    output logic            o_power_save,       // Auto power saving active
    output logic            o_speed_100,        // Strapped speed
    output logic            o_full_duplex_cfg,  // Strapped duplex
    output logic            o_autoneg_en,       // Autoneg enabled
    output scfg_pkg::scfg_if_t o_mac_if,        // MAC interface type
    output logic            o_indicator_mode2   // Second indicator mode
);
    // Synchronisers for live and strap pins
    localparam int SW = scfg_pkg::SCFG_SYNC_W;  // Synchronised pin count
    logic [SW-1:0] sync1_reg;                   // First stage
    logic [SW-1:0] sync2_reg;                   // Second stage
    wire  [SW-1:0] pins = {i_isolate_strap, i_repeater_strap, i_power_save_strap,
                           i_speed_strap, i_duplex_strap, i_autoneg_strap,
                           i_mac_if_select_strap, i_indicator_mode_strap,
                           i_col_strap, i_station_addr_pins};

    // Two-flop pin synchroniser
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    // Named fields of the synchronised pin word; only the second stage is read
    // The first stage may still be metastable, so nothing else looks at it
    wire       iso_s       = sync2_reg[scfg_pkg::SCFG_POS_ISO];     // Isolate, live
    wire       rep_s       = sync2_reg[scfg_pkg::SCFG_POS_REP];     // Repeater, live
    wire       psave_s     = sync2_reg[scfg_pkg::SCFG_POS_PSAVE];   // Power save, live
    wire       speed_s     = sync2_reg[scfg_pkg::SCFG_POS_SPEED];   // Speed strap
    wire       duplex_s    = sync2_reg[scfg_pkg::SCFG_POS_DUPLEX];  // Duplex strap
    wire       aneg_s      = sync2_reg[scfg_pkg::SCFG_POS_ANEG];    // Autoneg strap
    wire       mif_s       = sync2_reg[scfg_pkg::SCFG_POS_MIF];     // Interface select strap
    wire       lmod_s      = sync2_reg[scfg_pkg::SCFG_POS_LMOD];    // Indicator mode strap
    wire       strap_col_s = sync2_reg[scfg_pkg::SCFG_POS_COL];     // Collision strap
    wire [4:0] addr_s      = sync2_reg[scfg_pkg::SCFG_POS_ADDR_HI:0]; // Station address straps

    // Capture sequencing: wait for synchroniser to fill, then latch once
    logic [1:0] fill_reg;                       // Cycles since reset release
    logic       done_reg;                       // Straps latched, pins are outputs
    wire        capture = (fill_reg == scfg_pkg::SCFG_FILL_CYC) && !done_reg;

    // Count out the synchroniser latency after reset
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fill_reg <= 2'h0;
            done_reg <= 1'b0;
        end else begin
            if (fill_reg != scfg_pkg::SCFG_FILL_CYC) fill_reg <= fill_reg + 2'h1;
            if (capture) done_reg <= 1'b1;
        end
    end

    // Latched strap values
    logic       speed_reg, dpx_reg, an_reg, mii_reg, lmod_reg, col_reg;
    logic [4:0] addr_reg;                       // Station address

    // Take the straps once the fill is over, hold until next reset
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            speed_reg <= scfg_pkg::SCFG_SPEED_DEF;
            dpx_reg  <= scfg_pkg::SCFG_DUPLEX_DEF;
            an_reg   <= scfg_pkg::SCFG_ANEG_DEF;
            mii_reg  <= scfg_pkg::SCFG_MIIS_DEF;
            lmod_reg <= scfg_pkg::SCFG_LMOD_DEF;
            col_reg  <= scfg_pkg::SCFG_COL_DEF;
            addr_reg <= scfg_pkg::SCFG_ADDR_DEF;
        end else if (capture) begin
            speed_reg <= speed_s;
            dpx_reg  <= duplex_s;
            an_reg   <= aneg_s;
            mii_reg  <= mif_s;
            lmod_reg <= lmod_s;
            col_reg  <= strap_col_s;
            addr_reg <= addr_s;
        end
    end

    // Live level straps
    assign o_isolate       = iso_s;
    assign o_repeater_mode = rep_s;
    assign o_power_save    = psave_s;

    // Latched configuration outputs
    assign o_speed_100       = speed_reg;
    assign o_full_duplex_cfg = dpx_reg;
    assign o_autoneg_en      = an_reg;          // Low forces strapped speed/duplex
    assign o_station_addr    = addr_reg;
    assign o_indicator_mode2 = lmod_reg;
    assign o_mac_if = col_reg ? scfg_pkg::SCFG_IF_RMII :
                      (mii_reg ? scfg_pkg::SCFG_IF_MII : scfg_pkg::SCFG_IF_SNI);

    // Blink divider, runs only while activity or collision is present
    logic [31:0] bcnt_reg;                      // Half period counter
    logic        blink_reg;                     // Blink phase
    wire         act_s  = i_activity;
    wire         col_s  = i_collision;
    wire         busy   = act_s || col_s;
    wire         b_tick = (bcnt_reg == 32'(BLINK_CYC - 1));

    // Toggle blink phase at the fixed rate
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bcnt_reg  <= 32'h0;
            blink_reg <= 1'b0;
        end else if (!busy) begin
            bcnt_reg  <= 32'h0;
            blink_reg <= 1'b0;
        end else if (b_tick) begin
            bcnt_reg  <= 32'h0;
            blink_reg <= ~blink_reg;
        end else begin
            bcnt_reg  <= bcnt_reg + 32'h1;
        end
    end

    // Indicator functions, active high before polarity
    wire act_on   = act_s && blink_reg;         // Blank phase while traffic
    wire col_on   = col_s && blink_reg;
    wire l10      = i_link_up && !i_link_100m;
    wire l100     = i_link_up && i_link_100m;
    wire [4:0] m1 = {i_collision,
                     l100 && !act_on, l10 && !act_on,
                     i_full_duplex, i_link_up};
    wire [4:0] m2 = {1'b0, l100, l10,
                     (i_full_duplex || col_s) && !col_on,
                     i_link_up && !act_on};
    wire [4:0] ind_fn = lmod_reg ? m2 : m1;
    logic [4:0] ind_reg;                        // Registered pin levels

    // Apply per-pin polarity from latched address
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) ind_reg <= 5'h00;
        else           ind_reg <= ind_fn ^ addr_reg;
    end

    assign o_station_addr_ind = ind_reg;
    assign o_station_addr_oe  = {5{done_reg}};

    // Checks
    // Indicator checks wait one cycle past capture, so the new polarity has settled
    a_strap_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        done_reg |=> $stable(addr_reg) && $stable(speed_reg)) else $error("strap changed");
    a_pins_driven: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        done_reg |-> o_station_addr_oe == 5'h1F) else $error("pins not driven");
    a_cfg_default: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !done_reg |-> o_speed_100 == scfg_pkg::SCFG_SPEED_DEF) else $error("speed default");
    a_pins_input: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !done_reg |-> o_station_addr_oe == 5'h00) else $error("pins driven early");
    a_pol_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        done_reg && $past(done_reg) && $past(ind_fn) == 5'h00 |-> ind_reg == addr_reg)
        else $error("polarity wrong");
    a_if_rmii: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        col_reg |-> o_mac_if == scfg_pkg::SCFG_IF_RMII) else $error("rmii select");
    // Live strap follows its pin two cycles late, checked once the fill is over
    a_isolate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        done_reg |-> o_isolate == $past(i_isolate_strap, 2)) else $error("isolate lag");
    a_m2_unused: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        lmod_reg && $past(lmod_reg) |-> ind_reg[4] == addr_reg[4]) else $error("ind4 used");
    a_m1_link: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        done_reg && $past(done_reg) && !lmod_reg && $past(i_link_up)
        |-> ind_reg[0] != addr_reg[0]) else $error("link off");
    a_m1_collision: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        done_reg && $past(done_reg) && !lmod_reg && $past(i_collision)
        |-> ind_reg[4] != addr_reg[4]) else $error("collision off");
    // Collision lights the duplex pin in mode two outside the blank phase
    a_m2_dpx_col: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        done_reg && $past(done_reg) && lmod_reg && $past(i_collision) && !$past(blink_reg)
        |-> ind_reg[1] != addr_reg[1]) else $error("duplex collision off");
    a_blink_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !busy |=> !blink_reg && bcnt_reg == 32'h0) else $error("blink not reset");
    a_capture_once: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        capture |=> done_reg && addr_reg == $past(sync2_reg[4:0])) else $error("capture");
endmodule : scfg_strap_led
